//--- svd_regs.svh
// register offsets, field positions and timing constants of the supply detector
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH
`define SLD_CTRL_OFS 16'hff0c
`define SLD_IRQ_STAT_OFS 16'hff10
`define SLD_IRQ_MASK_OFS 16'hff14
`define SLD_LEVEL_OFS 16'hff18
`define SLD_ZERO_HI 7
`define SLD_ZERO_LO 6
`define SLD_FLAG_BIT 5
`define SLD_EN_BIT 4
`define SLD_CODE_HI 3
`define SLD_CODE_LO 0
`define SLD_CODE_W 4
`define SLD_MIN_CODE 4'h3
`define SLD_CODE_RST 4'h0
`define SLD_IRQ_DONE_BIT 0
`define SLD_IRQ_LOW_BIT 1
`define SLD_IRQ_W 2
`define SLD_SETTLE_US 500
`define SLD_CLK_MHZ 25
`define SLD_ADDR_W 16
`define SLD_RESP_OKAY 2'h0
`define SLD_RESP_SLVERR 2'h2
`endif

//--- svd_pkg.sv
// types shared by the supply detector control logic
package sld_pkg;
  // control register fields as seen in the low byte
  typedef struct packed {
    logic [1:0] zero;
    logic low_supply_flag;
    logic detector_enable;
    logic [3:0] threshold_code;
  } sld_ctrl_s;
  // detector power sequence
  typedef enum logic [1:0] {
    SLD_OFF,
    SLD_SETTLING,
    SLD_READY
  } sld_state_e;
endpackage : sld_pkg

//--- svd_ctrl.sv
// supply voltage detector control with an AXI4-Lite register slave
//
// The AXI4-Lite slave port was decided locally.
`include "svd_regs.svh"

// Notes on behaviour
// - four-bit code picks thirteen levels, three undefined
// - comparator active while enable holds one
// - enable falling captures result, powers detector down
// - flag one means below threshold, read only
// - flag D5, enable D4, code D3-D0, D7-D6 zero
// - enable reads back last written value
// - reset clears code, enable and flag
module sld_ctrl #(
  // settle time in clock cycles, 500 us at the system clock
  parameter int SETTLE_CYCLES = `SLD_SETTLE_US * `SLD_CLK_MHZ
) (
  // system clock and synchronous active-low reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus slave, write side
  input wire logic [`SLD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus slave, read side
  input wire logic [`SLD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // comparator result, high while supply is below the level
  input wire logic supply_below,
  // analog detector controls
  output logic detector_power,
  output logic [`SLD_CODE_W-1:0] detector_code,
  // level interrupt
  output logic irq
);

  // register state
  logic [`SLD_CODE_W-1:0] code_q; // threshold code
  logic enable_q; // detector enable as written
  logic flag_q; // captured comparison result
  logic [`SLD_IRQ_W-1:0] stat_q; // sticky events
  logic [`SLD_IRQ_W-1:0] mask_q; // event mask
  sld_pkg::sld_state_e state_q; // power sequence
  logic [$clog2(SETTLE_CYCLES+1)-1:0] cnt_q; // settle counter
  // bus capture
  logic aw_hold_q; // write address parked
  logic w_hold_q; // write data parked
  logic [`SLD_ADDR_W-1:0] awaddr_q; // parked write address
  logic [31:0] wdata_q; // parked write data
  logic [3:0] wstrb_q; // parked byte lanes
  logic wr_fire; // both halves of a write present
  logic enable_fall; // enable written from one to zero
  logic wr_ctrl; // write hits the control register
  logic new_en; // enable value after this write
  logic [`SLD_IRQ_W-1:0] ev; // events this cycle

  // register word decode, shared by reads and writes
  function automatic logic [1:0] reg_sel(input logic [`SLD_ADDR_W-1:0] a);
    logic [1:0] s;
    s = 2'h0;
    unique case (a)
      `SLD_CTRL_OFS: s = 2'h0;
      `SLD_IRQ_STAT_OFS: s = 2'h1;
      `SLD_IRQ_MASK_OFS: s = 2'h2;
      `SLD_LEVEL_OFS: s = 2'h3;
      default: s = 2'h0; // unmapped, masked by reg_hit
    endcase
    return s;
  endfunction : reg_sel

  // address names one of the four registers
  function automatic logic reg_hit(input logic [`SLD_ADDR_W-1:0] a);
    return (a == `SLD_CTRL_OFS) || (a == `SLD_IRQ_STAT_OFS) ||
      (a == `SLD_IRQ_MASK_OFS) || (a == `SLD_LEVEL_OFS);
  endfunction : reg_hit

  // code has a defined level
  function automatic logic code_valid(input logic [`SLD_CODE_W-1:0] c);
    return c >= `SLD_MIN_CODE;
  endfunction : code_valid

  // a write is carried out once both halves are parked and no answer waits
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  // control writes need lane 0, the only lane with fields
  assign wr_ctrl = wr_fire && reg_hit(awaddr_q) && reg_sel(awaddr_q) == 2'h0 && wstrb_q[0];
  assign new_en = wdata_q[`SLD_EN_BIT];
  // a zero written over a set enable is the capture moment
  assign enable_fall = wr_ctrl && enable_q && !new_en;
  assign ev[`SLD_IRQ_DONE_BIT] = enable_fall;
  assign ev[`SLD_IRQ_LOW_BIT] = enable_fall && supply_below;

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  // ready while the holding slot is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLD_RESP_OKAY;
    end else if (wr_fire) begin
      // unmapped writes are dropped and answered with an error
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_hit(awaddr_q) ? `SLD_RESP_OKAY : `SLD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // threshold code and enable, written through byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_q <= `SLD_CODE_RST;
      enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      // flag bit of the write data is not looked at here
      code_q <= wdata_q[`SLD_CODE_HI:`SLD_CODE_LO];
      enable_q <= new_en;
    end
  end

  // result latch: loaded only on a falling enable, write data ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (enable_fall) begin
      flag_q <= supply_below;
    end
  end

  // detector power and settle timing; the wait is only reported, not enforced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= sld_pkg::SLD_OFF;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        // off: wait for an enabling write
        sld_pkg::SLD_OFF: begin
          if (wr_ctrl && new_en) begin
            state_q <= sld_pkg::SLD_SETTLING;
            cnt_q <= '0;
          end
        end
        // settling: count out the stabilising time
        sld_pkg::SLD_SETTLING: begin
          if (enable_fall) begin
            state_q <= sld_pkg::SLD_OFF;
          end else if (cnt_q == $bits(cnt_q)'(SETTLE_CYCLES - 1)) begin
            state_q <= sld_pkg::SLD_READY;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        // ready: result is trustworthy until switched off
        sld_pkg::SLD_READY: begin
          if (enable_fall) begin
            state_q <= sld_pkg::SLD_OFF;
          end
        end
      endcase
    end
  end

  // drive analog comparator: power follows enable, code passes through
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detector_power <= 1'b0;
      detector_code <= `SLD_CODE_RST;
    end else begin
      // both track the register in the same edge as it is written
      detector_power <= wr_ctrl ? new_en : enable_q;
      detector_code <= wr_ctrl ? wdata_q[`SLD_CODE_HI:`SLD_CODE_LO] : code_q;
    end
  end

  // sticky events, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= ev | (stat_q & ~((wr_fire && reg_hit(awaddr_q) &&
        reg_sel(awaddr_q) == 2'h1 && wstrb_q[0]) ? wdata_q[`SLD_IRQ_W-1:0] : '0));
    end
  end

  // interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= '0;
    end else if (wr_fire && reg_hit(awaddr_q) && reg_sel(awaddr_q) == 2'h2 && wstrb_q[0]) begin
      mask_q <= wdata_q[`SLD_IRQ_W-1:0];
    end
  end

  // interrupt level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // read channel, one cycle after address
  always_ff @(posedge aclk) begin
    sld_pkg::sld_ctrl_s c; // control word as read, upper bits zero
    c = '0;
    c.low_supply_flag = flag_q;
    c.detector_enable = enable_q;
    c.threshold_code = code_q;
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SLD_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      // answer stands until taken
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reg_hit(s_axi_araddr) ? `SLD_RESP_OKAY : `SLD_RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      if (reg_hit(s_axi_araddr)) begin
        unique case (reg_sel(s_axi_araddr))
          2'h0: s_axi_rdata <= {24'h00_0000, c};
          2'h1: s_axi_rdata <= {30'h0000_0000, stat_q};
          2'h2: s_axi_rdata <= {30'h0000_0000, mask_q};
          2'h3: s_axi_rdata <= {29'h0000_0000, code_valid(code_q),
            state_q == sld_pkg::SLD_READY, state_q != sld_pkg::SLD_OFF};
        endcase
      end
    end else begin
      // idle: offer to take an address
      s_axi_arready <= 1'b1;
    end
  end

  // captured flag changes only on a falling enable
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable_fall |=> $stable(flag_q)) else $error("flag changed without capture");
  // capture takes the comparator level
  flag_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_fall |=> flag_q == $past(supply_below)) else $error("flag capture wrong");
  // detector powered down after falling enable
  power_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_fall |=> !detector_power) else $error("detector left on");
  // power follows enable
  power_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_q |-> detector_power) else $error("enabled detector unpowered");
  // read of control shows fields
  ctrl_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `SLD_CTRL_OFS |=>
    s_axi_rdata[`SLD_ZERO_HI:`SLD_ZERO_LO] == 2'h0 &&
    s_axi_rdata[`SLD_EN_BIT] == $past(enable_q) &&
    s_axi_rdata[`SLD_FLAG_BIT] == $past(flag_q)) else $error("control read wrong");
  // enable takes written value
  en_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> enable_q == $past(wdata_q[`SLD_EN_BIT])) else $error("enable not stored");
  // reset values
  reset_val_a: assert property (@(posedge aclk)
    !aresetn |=> code_q == `SLD_CODE_RST && !enable_q && !flag_q) else $error("reset values");
  // low flag event sets status
  low_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev[`SLD_IRQ_LOW_BIT] |=> stat_q[`SLD_IRQ_LOW_BIT]) else $error("event lost");
  // comparator receives the written threshold code
  code_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> detector_code == $past(wdata_q[`SLD_CODE_HI:`SLD_CODE_LO]))
    else $error("threshold code not passed on");
  // interrupt level follows unmasked status one cycle later
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq == $past(|(stat_q & mask_q))) else $error("interrupt level wrong");

endmodule : sld_ctrl

//--- supply_voltage_detect_ctrl_tb.sv
// self-checking bench for the supply detector control block
`include "svd_regs.svh"
module supply_voltage_detect_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 8; // short settle count for simulation
  localparam logic [15:0] CTRL = `SLD_CTRL_OFS; // control register
  localparam logic [15:0] STAT = `SLD_IRQ_STAT_OFS; // event status
  localparam logic [15:0] MASK = `SLD_IRQ_MASK_OFS; // event mask
  localparam logic [15:0] LEVEL = `SLD_LEVEL_OFS; // level status
  logic aclk = 1'b0; // system clock
  logic aresetn = 1'b0; // sync reset, active low
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000; // bus addresses
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000; // write payload
  logic [3:0] wstrb = 4'h1; // byte lanes
  logic below = 1'b0; // comparator input
  logic awready, wready, bvalid, arready, rvalid, power, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, data;
  logic [3:0] code;
  int err_total = 0; // mismatches
  int num_checks = 0; // comparisons
  // device under test with a short settle count
  sld_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply_below(below),
    .detector_power(power), .detector_code(code), .irq(irq)
  );
  // clock at 25 MHz
  initial begin
    forever #20 aclk = ~aclk;
  end
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one bus write, both halves offered together
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    chk("write answer", 32'h0000_0001, {31'h0, bvalid});
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  // one bus read
  task automatic rd(input logic [15:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    chk("read answer", 32'h0000_0001, {31'h0, rvalid});
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // reset state of control register and detector power
  task automatic t_reset;
    rd(CTRL);
    chk("ctrl after reset", 32'h0000_0000, data);
    chk("power after reset", 32'h0000_0000, {31'h0, power});
  endtask : t_reset
  // field layout, read-only bits, lane strobe
  task automatic t_fields;
    wr(CTRL, 32'h0000_00ff);
    rd(CTRL);
    chk("ctrl readback", 32'h0000_001f, data);
    chk("code out", 32'h0000_000f, {28'h0, code});
    chk("power on", 32'h0000_0001, {31'h0, power});
    wstrb <= 4'h0;
    wr(CTRL, 32'h0000_0000); // lane 0 off, ignored
    wstrb <= 4'h1;
    rd(CTRL);
    chk("enable kept", 32'h0000_001f, data);
    wr(CTRL, 32'h0000_0000);
  endtask : t_fields
  // full measurement, comparator flips after capture
  task automatic t_capture(input logic low);
    logic [31:0] flag;
    flag = low ? 32'h0000_0020 : 32'h0000_0000;
    below <= low;
    wr(CTRL, 32'h0000_0015);
    repeat (SETTLE + 2) @(posedge aclk);
    rd(LEVEL);
    chk("level status", 32'h0000_0007, data);
    wr(CTRL, 32'h0000_0005);
    below <= ~low;
    repeat (2) @(posedge aclk);
    chk("power off", 32'h0000_0000, {31'h0, power});
    rd(CTRL);
    chk("captured flag", flag | 32'h0000_0005, data);
    wr(CTRL, 32'h0000_0003); // disable again while off
    rd(CTRL);
    chk("latch held", flag | 32'h0000_0003, data);
  endtask : t_capture
  // every threshold code, defined levels from 3 up
  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      wr(CTRL, {28'h0, c[3:0]});
      rd(LEVEL);
      chk("code defined", (c >= 3) ? 32'h0000_0004 : 32'h0000_0000, data & 32'h0000_0004);
      chk("code out", {28'h0, c[3:0]}, {28'h0, code});
    end
  endtask : t_codes
  // interrupt raised, masked and cleared
  task automatic t_irq;
    wr(STAT, 32'h0000_0003);
    wr(MASK, 32'h0000_0000);
    t_capture(1'b1);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    rd(STAT);
    chk("status", 32'h0000_0003, data);
    wr(MASK, 32'h0000_0003);
    repeat (2) @(posedge aclk);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    wr(STAT, 32'h0000_0001);
    rd(STAT);
    chk("status w1c", 32'h0000_0002, data);
    wr(MASK, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk("irq low", 32'h0000_0000, {31'h0, irq});
    wr(STAT, 32'h0000_0002);
    rd(STAT);
    chk("status clear", 32'h0000_0000, data);
  endtask : t_irq
  // unmapped place answers with an error
  task automatic t_unmapped;
    rd(16'hff20);
    chk("rd resp", 32'h0000_0002, {30'h0, resp});
    chk("rd data", 32'h0000_0000, data);
    wr(16'hff20, 32'h0000_0001);
    chk("wr resp", 32'h0000_0002, {30'h0, resp});
  endtask : t_unmapped
  // reset in mid-run clears a set code, enable and captured flag
  task automatic t_midreset;
    below <= 1'b1;
    wr(CTRL, 32'h0000_001f);
    wr(CTRL, 32'h0000_000f);
    rd(CTRL);
    chk("flag before reset", 32'h0000_002f, data);
    wr(CTRL, 32'h0000_001f);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    below <= 1'b0;
    @(posedge aclk);
    rd(CTRL);
    chk("ctrl after mid reset", 32'h0000_0000, data);
    chk("power after mid reset", 32'h0000_0000, {31'h0, power});
    chk("code after mid reset", 32'h0000_0000, {28'h0, code});
  endtask : t_midreset
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fields();
    t_capture(1'b1);
    t_capture(1'b0);
    t_codes();
    t_irq();
    t_unmapped();
    t_midreset();
    final_report();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    final_report();
  end
endmodule : supply_voltage_detect_ctrl_tb
